// >>> design/shift_clock_gen.v
/*
 * baud-rate generator for master mode: divides pclk into the shift clock.
 * one half period lasts divisor+1 pclk cycles, so the shift clock rate is
 * pclk / (2 * (divisor + 1)). assumes run comes from logic on pclk.
 */
module shift_clock_gen #(
    parameter DIV_W = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire run,
    input wire [DIV_W-1:0] divisor,
    // shift clock level and falling-edge strobe
    output reg sck_q,
    output reg fall_q
);

reg [DIV_W-1:0] cnt_q;

// half-period counter; idle clock parks low so a new word starts cleanly
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cnt_q <= {DIV_W{1'b0}};
        sck_q <= 1'b0;
        fall_q <= 1'b0;
    end
    else if (!run)
    begin
        cnt_q <= {DIV_W{1'b0}};
        sck_q <= 1'b0;
        fall_q <= 1'b0;
    end
    else if (cnt_q >= divisor)
    begin
        cnt_q <= {DIV_W{1'b0}};
        sck_q <= ~sck_q;
        fall_q <= sck_q; // high to low edge coming
    end
    else
    begin
        cnt_q <= cnt_q + 1'b1;
        fall_q <= 1'b0;
    end
end

endmodule // shift_clock_gen

// >>> design/usart_rx_consts.vh
/*
 * constants for the synchronous serial receive path: register byte offsets,
 * bit positions inside the control and status registers, reset values.
 * assumes a 32-bit apb slave with one aligned word per 8-bit register.
 */
`ifndef USART_RX_CONSTS_VH
`define USART_RX_CONSTS_VH

// register byte offsets
`define OFS_RX_STATUS_CONTROL 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_STATUS_CONTROL 8'h08
`define OFS_BAUD_DIVISOR 8'h0C
`define OFS_INT_FLAGS 8'h10
`define OFS_INT_ENABLES 8'h14
`define OFS_INT_PRIORITIES 8'h18
`define OFS_CORE_CONTROL 8'h1C

// receive_status_control fields
`define RS_SERIAL_PORT_EN 7
`define RS_NINE_BIT_SEL 6
`define RS_SINGLE_WORD_EN 5
`define RS_CONTINUOUS_EN 4
`define RS_FRAMING_ERR 2
`define RS_OVERRUN_ERR 1
`define RS_NINTH_BIT 0

// transmit_status_control fields
`define TS_CLOCK_SOURCE 7
`define TS_SYNC_MODE 4
`define TS_SHIFT_IDLE 1
`define TS_WRITE_MASK 8'hFD

// interrupt flag, enable and priority layout
`define IF_RECEIVE 5

// core_control fields
`define CC_GLOBAL_INT_EN 7
`define CC_PERIPH_INT_EN 6

// reset values
`define RST_RX_STATUS_CONTROL 8'h00
`define RST_RX_DATA 8'h00
`define RST_TX_STATUS_CONTROL 8'h02
`define RST_BAUD_DIVISOR 8'h00
`define RST_INT_REG 8'h00

`endif

// >>> design/usart_sync_rx.v
/*
 * synchronous serial receive path with apb register access, master and
 * slave shift clock, 8 or 9 bit words, sticky interrupt flags and wake.
 * assumes the serial peer shifts data lsb first and changes data while
 * the shift clock is high; pins are asynchronous to pclk.
 */
`include "usart_rx_consts.vh"

module usart_sync_rx #(
    parameter DIV_W = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // serial pins
    input wire data_in,
    input wire shift_clk_in,
    output reg shift_clk_out_q,
    output reg shift_clk_oe_q,
    // core power state and interrupts
    input wire core_sleep,
    output reg irq_q,
    output reg wake_q,
    output reg vector_req_q
);

// control and status storage
reg serial_port_enable_q;
reg nine_bit_receive_select_q;
reg single_word_receive_enable_q;
reg continuous_receive_enable_q;
reg overrun_error_flag_q;
reg received_ninth_bit_q;
reg [7:0] rcv_data_q;
reg data_full_q;
reg [7:0] transmit_status_control_q;
reg [DIV_W-1:0] divisor_q;
reg [7:0] flags_q;
reg [7:0] enables_q;
reg [7:0] priorities_q;
reg global_interrupt_enable_q;
reg peripheral_interrupt_enable_q;

// receive datapath; the last bit of a word never lands here
reg [7:0] shift_q;
reg [3:0] bit_cnt_q;

// pin synchronisers
reg data_s1_q;
reg data_s2_q;
reg ck_s1_q;
reg ck_s2_q;
reg ck_s3_q;

// bus decode
wire acc = psel && penable && pready;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;
wire [7:0] wdat = pwdata[7:0];
reg [7:0] rmux;
reg mapped;

// mode decode
wire sync_mode = transmit_status_control_q[`TS_SYNC_MODE];
wire master = serial_port_enable_q && sync_mode && transmit_status_control_q[`TS_CLOCK_SOURCE];
wire slave = serial_port_enable_q && sync_mode && !transmit_status_control_q[`TS_CLOCK_SOURCE];
wire single_en = single_word_receive_enable_q && master && !continuous_receive_enable_q;
wire rx_en = (continuous_receive_enable_q || single_en) && (master || slave) && !overrun_error_flag_q;
// master clock halts in sleep; the slave is clocked by the peer
wire gen_run = master && rx_en && !core_sleep;
wire gen_sck;
wire gen_fall;
wire slave_fall = ck_s3_q && !ck_s2_q;
wire sample = rx_en && (master ? gen_fall : (slave && slave_fall));
wire last_bit = (bit_cnt_q == (nine_bit_receive_select_q ? 4'd8 : 4'd7));
wire word_done = sample && last_bit;
// the last bit is sampled in the hand-off cycle, so take it from the pin stage
wire [8:0] word_now = nine_bit_receive_select_q ? {data_s2_q, shift_q} : {1'b0, data_s2_q, shift_q[6:0]};
wire rcv_event = word_done && !data_full_q;
wire ovr_event = word_done && data_full_q;
wire int_pend = |(flags_q & enables_q);

shift_clock_gen #(
    .DIV_W(DIV_W)
) u_shift_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(gen_run),
    .divisor(divisor_q),
    .sck_q(gen_sck),
    .fall_q(gen_fall)
);

// two flip-flops on each pin before any logic looks at it
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        data_s1_q <= 1'b0;
        data_s2_q <= 1'b0;
        ck_s1_q <= 1'b0;
        ck_s2_q <= 1'b0;
        ck_s3_q <= 1'b0;
    end
    else
    begin
        data_s1_q <= data_in;
        data_s2_q <= data_s1_q;
        ck_s1_q <= shift_clk_in;
        ck_s2_q <= ck_s1_q;
        ck_s3_q <= ck_s2_q; // edge history, reads the second stage only
    end
end

// shift clock pin: driven only in master mode
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        shift_clk_out_q <= 1'b0;
        shift_clk_oe_q <= 1'b0;
    end
    else
    begin
        shift_clk_out_q <= master && gen_sck;
        shift_clk_oe_q <= master;
    end
end

// bit collection, lsb first; count restarts whenever reception is off
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        shift_q <= 8'h00;
        bit_cnt_q <= 4'h0;
    end
    else if (!rx_en)
    begin
        bit_cnt_q <= 4'h0;
    end
    else if (sample)
    begin
        if (!last_bit)
            shift_q[bit_cnt_q[2:0]] <= data_s2_q;
        bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
    end
end

// register read mux, unmapped offsets answer with an error
always @*
begin
    rmux = 8'h00;
    mapped = 1'b1;
    if (paddr == `OFS_RX_STATUS_CONTROL)
    begin
        rmux[`RS_SERIAL_PORT_EN] = serial_port_enable_q;
        rmux[`RS_NINE_BIT_SEL] = nine_bit_receive_select_q;
        rmux[`RS_SINGLE_WORD_EN] = single_word_receive_enable_q;
        rmux[`RS_CONTINUOUS_EN] = continuous_receive_enable_q;
        rmux[`RS_FRAMING_ERR] = 1'b0; // no stop bit to check in sync mode
        rmux[`RS_OVERRUN_ERR] = overrun_error_flag_q;
        rmux[`RS_NINTH_BIT] = received_ninth_bit_q;
    end
    else if (paddr == `OFS_RX_DATA)
        rmux = rcv_data_q;
    else if (paddr == `OFS_TX_STATUS_CONTROL)
        rmux = transmit_status_control_q;
    else if (paddr == `OFS_BAUD_DIVISOR)
        rmux = divisor_q;
    else if (paddr == `OFS_INT_FLAGS)
        rmux = flags_q;
    else if (paddr == `OFS_INT_ENABLES)
        rmux = enables_q;
    else if (paddr == `OFS_INT_PRIORITIES)
        rmux = priorities_q;
    else if (paddr == `OFS_CORE_CONTROL)
    begin
        rmux[`CC_GLOBAL_INT_EN] = global_interrupt_enable_q;
        rmux[`CC_PERIPH_INT_EN] = peripheral_interrupt_enable_q;
    end
    else
        mapped = 1'b0;
end

// apb answer: one wait state so read data comes straight from a flop
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
        pready <= 1'b1;
        prdata <= {24'h00_0000, pwrite ? 8'h00 : rmux};
        pslverr <= !mapped;
    end
    else
    begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
end

// control registers written by software
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        serial_port_enable_q <= 1'b0;
        nine_bit_receive_select_q <= 1'b0;
        continuous_receive_enable_q <= 1'b0;
        transmit_status_control_q <= `RST_TX_STATUS_CONTROL;
        divisor_q <= `RST_BAUD_DIVISOR;
        enables_q <= `RST_INT_REG;
        priorities_q <= `RST_INT_REG;
        global_interrupt_enable_q <= 1'b0;
        peripheral_interrupt_enable_q <= 1'b0;
    end
    else if (wr && mapped)
    begin
        if (paddr == `OFS_RX_STATUS_CONTROL)
        begin
            serial_port_enable_q <= wdat[`RS_SERIAL_PORT_EN];
            nine_bit_receive_select_q <= wdat[`RS_NINE_BIT_SEL];
            continuous_receive_enable_q <= wdat[`RS_CONTINUOUS_EN];
        end
        else if (paddr == `OFS_TX_STATUS_CONTROL)
            // shifter-idle bit is status, it always reads one
            transmit_status_control_q <= (wdat & `TS_WRITE_MASK) | `RST_TX_STATUS_CONTROL;
        else if (paddr == `OFS_BAUD_DIVISOR)
            divisor_q <= wdat[DIV_W-1:0];
        else if (paddr == `OFS_INT_ENABLES)
            enables_q <= wdat;
        else if (paddr == `OFS_INT_PRIORITIES)
            priorities_q <= wdat;
        else if (paddr == `OFS_CORE_CONTROL)
        begin
            global_interrupt_enable_q <= wdat[`CC_GLOBAL_INT_EN];
            peripheral_interrupt_enable_q <= wdat[`CC_PERIPH_INT_EN];
        end
    end
end

// single-word enable: set by software, dropped by hardware after the word
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        single_word_receive_enable_q <= 1'b0;
    else if (wr && paddr == `OFS_RX_STATUS_CONTROL)
        single_word_receive_enable_q <= wdat[`RS_SINGLE_WORD_EN];
    else if (word_done && single_en)
        single_word_receive_enable_q <= 1'b0;
end

// word hand-off into the data register; a full register means overrun
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rcv_data_q <= `RST_RX_DATA;
        received_ninth_bit_q <= 1'b0;
        data_full_q <= 1'b0;
    end
    else if (rcv_event)
    begin
        rcv_data_q <= word_now[7:0];
        received_ninth_bit_q <= word_now[8];
        data_full_q <= 1'b1;
    end
    else if (rd && paddr == `OFS_RX_DATA)
        data_full_q <= 1'b0;
end

// overrun error: latched until continuous enable is written to zero
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        overrun_error_flag_q <= 1'b0;
    else if (ovr_event)
        overrun_error_flag_q <= 1'b1; // new word would clobber unread data
    else if (wr && paddr == `OFS_RX_STATUS_CONTROL && !wdat[`RS_CONTINUOUS_EN])
        overrun_error_flag_q <= 1'b0;
end

// sticky flags, write one to clear; a new event wins over the clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        flags_q <= `RST_INT_REG;
    else
    begin
        if (wr && paddr == `OFS_INT_FLAGS)
            flags_q <= flags_q & ~wdat;
        if (rcv_event)
            flags_q[`IF_RECEIVE] <= 1'b1;
    end
end

// interrupt, wake and vector request, all from flops
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_q <= 1'b0;
        wake_q <= 1'b0;
        vector_req_q <= 1'b0;
    end
    else
    begin
        irq_q <= int_pend;
        wake_q <= core_sleep && int_pend;
        vector_req_q <= int_pend && global_interrupt_enable_q && peripheral_interrupt_enable_q;
    end
end

endmodule // usart_sync_rx

// >>> tb/sync_peer_model.sv
/* serial peer: makes the shift clock in slave mode, answers the block's
   clock in master mode; lsb first. */
module sync_peer_model (
    // clock from the block
    input logic master_clk,
    // lines into the block
    output logic peer_clk,
    output logic peer_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] word_q = 9'h000;
    int bit_q = 9;
    initial
    begin
        peer_clk = 1'b0;
        peer_data = 1'b0;
    end
    // clock stands low between words; bits change while high, the line flips after the word
    task automatic send(input logic [8:0] w, input int n);
        #1.3;
        for (int i = 0; i < n; i++)
        begin
            peer_clk = 1'b1;
            peer_data = w[i];
            #32 peer_clk = 1'b0;
            #32;
        end
        peer_data = ~peer_data; // released line keeps no value
    endtask
    task automatic load(input logic [8:0] w);
        word_q = w;
        bit_q = 0;
    endtask
    // next bit on each rising edge, garbage after the word
    always @(posedge master_clk)
    begin
        peer_data = (bit_q < 9) ? word_q[bit_q] : ~peer_data;
        bit_q++;
    end
endmodule // sync_peer_model

// >>> tb/test_usart_sync_rx.sv
/* bench for the receive path: apb tasks and words from the peer model.
   assumes checker and peer files are compiled first. */
`include "usart_rx_consts.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_usart_sync_rx;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, core_sleep, pready, pslverr;
    logic data_in, sclk_in, sck_out, sck_oe, irq, wake, vec, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int checks = 0;
    int mismatches = 0;
    usart_sync_rx #(.DIV_W(8)) i_usart_sync_rx (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_in(data_in), .shift_clk_in(sclk_in), .shift_clk_out_q(sck_out), .shift_clk_oe_q(sck_oe),
        .core_sleep(core_sleep), .irq_q(irq), .wake_q(wake), .vector_req_q(vec));
    sync_peer_model i_sync_peer_model (.master_clk(sck_out), .peer_clk(sclk_in), .peer_data(data_in));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK($sformatf("register %h", a), {24'h00_0000, e}, rd)
    endtask
    // bounded wait for the interrupt, plus one edge for the outputs to land
    task automatic wait_irq;
        int n;
        for (n = 0; n < 1000 && irq !== 1'b1; n++)
            @(posedge pclk);
        if (n >= 1000)
        begin
            mismatches++;
            complete_run();
        end
        @(posedge pclk);
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        core_sleep = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            chk_rd(8'(i * 4), i == 2 ? 8'h02 : 8'h00);
        xfer(1'b0, 8'h20, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        $display("test reset done");
        // slave, nine-bit, continuous, interrupts on
        xfer(1'b1, `OFS_TX_STATUS_CONTROL, 32'h0000_0010);
        xfer(1'b1, `OFS_INT_ENABLES, 32'h0000_0020);
        xfer(1'b1, `OFS_CORE_CONTROL, 32'h0000_00C0);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_00D0);
        i_sync_peer_model.send(9'h1A5, 9);
        wait_irq();
        `CHK("vector", 1'b1, vec)
        chk_rd(`OFS_INT_FLAGS, 8'h20);
        chk_rd(`OFS_RX_STATUS_CONTROL, 8'hD1);
        chk_rd(`OFS_RX_DATA, 8'hA5);
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test slave done");
        // second word fills the data register, third overruns
        i_sync_peer_model.send(9'h05A, 9);
        i_sync_peer_model.send(9'h13C, 9);
        xfer(1'b1, `OFS_INT_ENABLES, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        chk_rd(`OFS_RX_DATA, 8'h5A);
        xfer(1'b0, `OFS_RX_STATUS_CONTROL, 32'h0000_0000);
        `CHK("overrun", 1'b1, rd[1])
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_00C0);
        xfer(1'b0, `OFS_RX_STATUS_CONTROL, 32'h0000_0000);
        `CHK("errors", 2'b00, rd[2:1])
        $display("test overrun done");
        // eight-bit word while the core sleeps
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        xfer(1'b1, `OFS_INT_ENABLES, 32'h0000_0020);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_0090);
        core_sleep <= 1'b1;
        i_sync_peer_model.send(9'h03C, 8);
        wait_irq();
        `CHK("wake", 1'b1, wake)
        core_sleep <= 1'b0;
        chk_rd(`OFS_RX_DATA, 8'h3C);
        $display("test sleep done");
        // slave with only the single-word enable: the peer's word is ignored
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_00A0);
        i_sync_peer_model.send(9'h0FF, 8);
        repeat (8) @(posedge pclk);
        chk_rd(`OFS_INT_FLAGS, 8'h00);
        `CHK("slave clock pin", 1'b0, sck_oe)
        $display("test slave single done");
        // master, single word, half period of four cycles
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_0080);
        xfer(1'b1, `OFS_BAUD_DIVISOR, 32'h0000_0003);
        chk_rd(`OFS_BAUD_DIVISOR, 8'h03);
        xfer(1'b1, `OFS_TX_STATUS_CONTROL, 32'h0000_0090);
        i_sync_peer_model.load(9'h0C3);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_00A0);
        wait_irq();
        `CHK("clock enable", 1'b1, sck_oe)
        chk_rd(`OFS_RX_DATA, 8'hC3);
        chk_rd(`OFS_RX_STATUS_CONTROL, 8'h80);
        $display("test master done");
        // master with both enables: continuous wins, words follow back to back
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        i_sync_peer_model.load(9'h1E7);
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_00B0);
        wait_irq();
        chk_rd(`OFS_RX_DATA, 8'hE7);
        chk_rd(`OFS_RX_STATUS_CONTROL, 8'hB0);
        xfer(1'b1, `OFS_INT_FLAGS, 32'h0000_0020);
        repeat (2) @(posedge pclk);
        // second word: ninth model bit, then the model's alternating filler
        wait_irq();
        chk_rd(`OFS_RX_DATA, 8'h55);
        // master clock must hold still while the core sleeps
        core_sleep <= 1'b1;
        repeat (40) @(posedge pclk);
        core_sleep <= 1'b0;
        xfer(1'b1, `OFS_RX_STATUS_CONTROL, 32'h0000_0080);
        $display("test continuous done");
        complete_run();
    end
endmodule // test_usart_sync_rx
bind usart_sync_rx usart_sync_rx_checker i_usart_sync_rx_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clk_out_q(shift_clk_out_q), .shift_clk_oe_q(shift_clk_oe_q), .core_sleep(core_sleep),
    .irq_q(irq_q), .wake_q(wake_q), .vector_req_q(vector_req_q));

// >>> tb/usart_sync_rx_assertions.sv
/* checker for the receive path: apb handshake, interrupt, wake, clock pin.
   sees only top ports; bound from the bench. */
module usart_sync_rx_checker (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // pins and power
    input logic shift_clk_out_q,
    input logic shift_clk_oe_q,
    input logic core_sleep,
    input logic irq_q,
    input logic wake_q,
    input logic vector_req_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // setup cycle followed by the first access cycle
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_after_access: assert property (s_access |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata outside access");
    // the flag only drops through a software write, two edges later
    a_irq_clear_cause: assert property ($fell(irq_q) |-> $past(psel && pwrite && pready, 2))
        else $error("irq dropped without write");
    a_wake_needs_sleep: assert property (wake_q |-> irq_q && $past(core_sleep))
        else $error("wake without sleep");
    a_vector_needs_irq: assert property (vector_req_q |-> irq_q)
        else $error("vector without irq");
    a_clk_only_master: assert property ($rose(shift_clk_out_q) |-> shift_clk_oe_q)
        else $error("clock driven in slave mode");
    a_clk_stops_sleep: assert property (core_sleep [*4] |-> !$rose(shift_clk_out_q))
        else $error("clock runs in sleep");
endmodule // usart_sync_rx_checker
